//--- core/hpbc_dec_if.sv
`timescale 1ns/1ps
interface hpbc_dec_if;
  logic        vga_en;
  logic        is_io;
  logic [31:0] addr;
  logic        exclude;
  modport ctl (output vga_en, output is_io, output addr, input exclude);
  modport dec (input vga_en, input is_io, input addr, output exclude);
endinterface

//--- core/hpbc_decode.sv
`timescale 1ns/1ps
module hpbc_decode
  import hpbc_pkg::*;
(
  hpbc_dec_if.dec d
);
  logic in_vga_mem;
  logic in_vga_io;

  assign in_vga_mem = (d.addr >= VGA_MEM_LO) && (d.addr <= VGA_MEM_HI);
  assign in_vga_io  = ((d.addr >= VGA_IO_A_LO) && (d.addr <= VGA_IO_A_HI))
                   || ((d.addr >= VGA_IO_B_LO) && (d.addr <= VGA_IO_B_HI));
  // I/O in the VGA range is never taken; memory only when a VGA device sits on PCI
  assign d.exclude  = d.is_io ? in_vga_io : (d.vga_en && in_vga_mem);
endmodule

//--- core/hpbc_pkg.sv
package hpbc_pkg;
  localparam logic [7:0]  ADDR_CMD       = 8'h04;
  localparam logic [7:0]  ADDR_STS       = 8'h06;
  localparam logic [7:0]  ADDR_BCTL      = 8'h3e;
  localparam int          CMD_SERR_BIT   = 8;
  localparam int          STS_SYSERR_BIT = 14;
  localparam int          STS_DPE_BIT    = 15;
  localparam int          BC_PERR_BIT    = 0;
  localparam int          BC_SERR_BIT    = 1;
  localparam int          BC_ISA_BIT     = 2;
  localparam int          BC_VGA_BIT     = 3;
  localparam int          BC_VGA16_BIT   = 4;
  localparam int          BC_MAMODE_BIT  = 5;
  localparam logic [15:0] BCTL_RW_MASK   = 16'h0b3f;
  localparam logic [15:0] CMD_RW_MASK    = 16'h0100;
  localparam logic [15:0] BCTL_RESET     = 16'h0000;
  localparam logic [15:0] CMD_RESET      = 16'h0000;
  localparam logic [15:0] STS_RESET      = 16'h0000;
  localparam logic [31:0] VGA_MEM_LO     = 32'h000a_0000;
  localparam logic [31:0] VGA_MEM_HI     = 32'h000b_ffff;
  localparam logic [31:0] VGA_IO_A_LO    = 32'h0000_03b0;
  localparam logic [31:0] VGA_IO_A_HI    = 32'h0000_03bb;
  localparam logic [31:0] VGA_IO_B_LO    = 32'h0000_03c0;
  localparam logic [31:0] VGA_IO_B_HI    = 32'h0000_03df;
  localparam logic [31:0] MA_READ_DATA   = 32'hffff_ffff;
  localparam logic [4:0]  DW_ONE         = 5'h01;
  localparam logic [1:0]  CST_OK         = 2'h0;
  localparam logic [1:0]  CST_MASTER_AB  = 2'h1;
  localparam logic [1:0]  CST_TARGET_AB  = 2'h2;
  typedef enum logic {HPBC_IDLE, HPBC_STREAM} hpbc_cmp_e;
endpackage

//--- core/hpbc_top.sv
// Implementation choices: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module hpbc_top
  import hpbc_pkg::*;
(
  input  wire logic        mclk,
  input  wire logic        nrst,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        pci_ma_valid,
  input  wire logic        pci_ma_posted,
  input  wire logic        pci_ma_read,
  input  wire logic [4:0]  pci_ma_dwords,
  output logic             cmp_valid,
  output logic      [1:0]  cmp_status,
  output logic      [31:0] cmp_data,
  input  wire logic        hub_ma_valid,
  input  wire logic [31:0] hub_ma_data,
  output logic             prd_valid,
  output logic      [31:0] prd_data,
  output logic             prd_target_abort,
  output logic             prd_flush,
  input  wire logic        pci_cyc_valid,
  input  wire logic        pci_cyc_io,
  input  wire logic        pci_cyc_hit,
  input  wire logic [31:0] pci_cyc_addr,
  output logic             pci_claim,
  input  wire logic        hub_io_valid,
  input  wire logic        hub_io_local,
  output logic             hub_io_to_pci,
  input  wire logic        serr_n,
  input  wire logic        nmi_to_smi,
  output logic             nmi_req,
  output logic             system_management_interrupt,
  input  wire logic        pci_par_err,
  output logic             perr_report
);
  logic [15:0] bctl_ff;
  logic [15:0] cmd_ff;
  logic        syserr_ff;
  logic        dpe_ff;
  logic        nxt_syserr;
  logic        nxt_dpe;
  logic        ma_mode;
  logic        serr_path_en;
  logic        posted_ma;
  logic        cr_ma;
  logic        serr_hit;
  logic        par_hit;
  logic [4:0]  dw_left_ff;
  hpbc_cmp_e   cmp_st_ff;
  hpbc_dec_if  dec ();

  assign ma_mode      = bctl_ff[BC_MAMODE_BIT];
  assign serr_path_en = bctl_ff[BC_SERR_BIT] && cmd_ff[CMD_SERR_BIT];
  assign posted_ma    = pci_ma_valid && pci_ma_posted;
  assign cr_ma        = pci_ma_valid && !pci_ma_posted && (cmp_st_ff == HPBC_IDLE);
  assign serr_hit     = !serr_n && serr_path_en;
  assign par_hit      = pci_par_err && bctl_ff[BC_PERR_BIT];

  // Register writes; bridge-control bits 2, 4, 8, 9 and 11 are stored only and steer nothing, command bit 8 gates SERR
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      bctl_ff <= BCTL_RESET;
    else if (reg_wr && reg_addr == ADDR_BCTL)
      bctl_ff <= reg_wdata & BCTL_RW_MASK;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      cmd_ff <= CMD_RESET;
    else if (reg_wr && reg_addr == ADDR_CMD)
      cmd_ff <= reg_wdata & CMD_RW_MASK;
  end

  // Status bits: write one to clear, a new event wins over the clear
  always_comb
  begin
    nxt_syserr = syserr_ff;
    nxt_dpe    = dpe_ff;
    if (reg_wr && reg_addr == ADDR_STS)
    begin
      nxt_syserr = syserr_ff && !reg_wdata[STS_SYSERR_BIT];
      nxt_dpe    = dpe_ff && !reg_wdata[STS_DPE_BIT];
    end
    if (serr_hit)
      nxt_syserr = 1'b1;
    if (posted_ma && ma_mode && serr_path_en)
      nxt_syserr = 1'b1;
    if (par_hit)
      nxt_dpe = 1'b1;
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      syserr_ff <= 1'b0;
      dpe_ff    <= 1'b0;
    end
    else
    begin
      syserr_ff <= nxt_syserr;
      dpe_ff    <= nxt_dpe;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= 16'h0000;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        ADDR_BCTL: reg_rdata <= bctl_ff;
        ADDR_CMD:  reg_rdata <= cmd_ff;
        ADDR_STS:  reg_rdata <= {dpe_ff, syserr_ff, 14'h0000};
        default:   reg_rdata <= 16'h0000;
      endcase
    end
    else
      reg_rdata <= 16'h0000;
  end

  // Hub-to-PCI completions; posted writes never produce one
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      cmp_st_ff  <= HPBC_IDLE;
      dw_left_ff <= 5'h00;
      cmp_valid  <= 1'b0;
      cmp_status <= CST_OK;
      cmp_data   <= 32'h0000_0000;
    end
    else
    begin
      unique case (cmp_st_ff)
        HPBC_IDLE:
        begin
          cmp_valid <= 1'b0;
          if (cr_ma)
          begin
            cmp_valid  <= 1'b1;
            cmp_status <= ma_mode ? CST_TARGET_AB : CST_MASTER_AB;
            cmp_data   <= pci_ma_read ? MA_READ_DATA : 32'h0000_0000;
            if (pci_ma_read && pci_ma_dwords > DW_ONE)
            begin
              dw_left_ff <= pci_ma_dwords - DW_ONE;
              cmp_st_ff  <= HPBC_STREAM;
            end
          end
        end
        HPBC_STREAM:
        begin
          cmp_valid  <= 1'b1;
          dw_left_ff <= dw_left_ff - DW_ONE;
          if (dw_left_ff == DW_ONE)
            cmp_st_ff <= HPBC_IDLE;
        end
      endcase
    end
  end

  // PCI reads that master-abort on the hub; PCI writes have no abort path
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      prd_valid        <= 1'b0;
      prd_data         <= 32'h0000_0000;
      prd_target_abort <= 1'b0;
      prd_flush        <= 1'b0;
    end
    else
    begin
      prd_valid        <= hub_ma_valid && !ma_mode;
      prd_data         <= (hub_ma_valid && !ma_mode) ? hub_ma_data : 32'h0000_0000;
      prd_target_abort <= hub_ma_valid && ma_mode;
      prd_flush        <= hub_ma_valid && ma_mode;
    end
  end

  assign dec.vga_en = bctl_ff[BC_VGA_BIT];
  assign dec.is_io  = pci_cyc_io;
  assign dec.addr   = pci_cyc_addr;

  hpbc_decode u_decode
  (
    .d (dec.dec)
  );

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      pci_claim     <= 1'b0;
      hub_io_to_pci <= 1'b0;
    end
    else
    begin
      pci_claim     <= pci_cyc_valid && pci_cyc_hit && !dec.exclude;
      hub_io_to_pci <= hub_io_valid && !hub_io_local;
    end
  end

  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      nmi_req                     <= 1'b0;
      system_management_interrupt <= 1'b0;
      perr_report                 <= 1'b0;
    end
    else
    begin
      nmi_req                     <= serr_hit && !nmi_to_smi;
      system_management_interrupt <= serr_hit && nmi_to_smi;
      perr_report                 <= par_hit;
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence s_one_dw_read;
    cr_ma && pci_ma_read && pci_ma_dwords == DW_ONE;
  endsequence
  sequence s_single_beat;
    cmp_valid ##1 !cmp_valid;
  endsequence

  a_ma_status_quiet: assert property (cr_ma && !ma_mode
    |=> cmp_valid && cmp_status == CST_MASTER_AB)
    else $error("quiet mode completion lacks master-abort status");
  a_ma_status_error: assert property (cr_ma && ma_mode
    |=> cmp_valid && cmp_status == CST_TARGET_AB)
    else $error("error mode completion lacks target-abort status");
  a_read_all_ones: assert property (cmp_valid && cmp_st_ff == HPBC_STREAM
    |-> cmp_data == MA_READ_DATA)
    else $error("aborted read data not all ones");
  a_read_one_beat: assert property (s_one_dw_read |=> s_single_beat)
    else $error("single dword read gave wrong beat count");
  a_posted_drop: assert property (posted_ma && cmp_st_ff == HPBC_IDLE |=> !cmp_valid)
    else $error("posted write produced a completion");
  a_posted_syserr: assert property (posted_ma && ma_mode && serr_path_en |=> syserr_ff)
    else $error("posted abort did not set system error status");
  a_hub_rd_data: assert property (hub_ma_valid && !ma_mode
    |=> prd_valid && prd_data == $past(hub_ma_data))
    else $error("abort packet data not returned");
  a_hub_rd_abort: assert property (hub_ma_valid && ma_mode
    |=> prd_target_abort && prd_flush && !prd_valid)
    else $error("hub abort not ended with target abort and flush");
  a_vga_mem_excl: assert property (pci_cyc_valid && !pci_cyc_io && bctl_ff[BC_VGA_BIT]
    && pci_cyc_addr >= VGA_MEM_LO && pci_cyc_addr <= VGA_MEM_HI |=> !pci_claim)
    else $error("VGA memory cycle claimed");
  a_vga_io_never: assert property (pci_cyc_valid && pci_cyc_io
    && pci_cyc_addr >= VGA_IO_B_LO && pci_cyc_addr <= VGA_IO_B_HI |=> !pci_claim)
    else $error("VGA I/O cycle claimed");
  a_vga_io_low: assert property (pci_cyc_valid && pci_cyc_io
    && pci_cyc_addr >= VGA_IO_A_LO && pci_cyc_addr <= VGA_IO_A_HI |=> !pci_claim)
    else $error("low VGA I/O cycle claimed");
  a_serr_report: assert property (!serr_n && serr_path_en
    |=> syserr_ff && (nmi_req || system_management_interrupt))
    else $error("system error not reported");
  a_serr_masked: assert property (!serr_path_en
    |=> !nmi_req && !system_management_interrupt)
    else $error("system error raised an interrupt while disabled");
  a_parity_off: assert property (!bctl_ff[BC_PERR_BIT] && !dpe_ff
    |=> !perr_report && !dpe_ff)
    else $error("parity reported while disabled");
  a_parity_on: assert property (par_hit |=> perr_report && dpe_ff)
    else $error("enabled parity error not reported");
  a_io_forward: assert property (hub_io_valid && !hub_io_local |=> hub_io_to_pci)
    else $error("hub I/O cycle not forwarded");
  a_io_local_kept: assert property (hub_io_valid && hub_io_local |=> !hub_io_to_pci)
    else $error("local hub I/O cycle forwarded");
endmodule

//--- tb/hpbc_partner.sv
`timescale 1ns/1ps
module hpbc_partner
(
  input  wire logic        mclk,
  output logic             pci_ma_valid,
  output logic             pci_ma_posted,
  output logic             pci_ma_read,
  output logic      [4:0]  pci_ma_dwords,
  output logic             hub_ma_valid,
  output logic      [31:0] hub_ma_data
);
  initial
  begin
    {pci_ma_valid, pci_ma_posted, pci_ma_read, pci_ma_dwords} = '0;
    {hub_ma_valid, hub_ma_data} = '0;
  end
  // Qualifiers are inverted once the pulse ends so stale values never look valid
  task automatic pci_abort(input logic p, input logic r, input logic [4:0] n);
    @(posedge mclk);
    pci_ma_valid  <= 1'b1;
    pci_ma_posted <= p;
    pci_ma_read   <= r;
    pci_ma_dwords <= n;
    @(posedge mclk);
    pci_ma_valid  <= 1'b0;
    pci_ma_posted <= ~p;
    pci_ma_read   <= ~r;
    pci_ma_dwords <= ~n;
  endtask
  task automatic hub_abort(input logic [31:0] d);
    @(posedge mclk);
    hub_ma_valid <= 1'b1;
    hub_ma_data  <= d;
    @(posedge mclk);
    hub_ma_valid <= 1'b0;
    hub_ma_data  <= ~d;
  endtask
endmodule

//--- tb/hub_to_pci_bridge_control_tb.sv
`timescale 1ns/1ps
module hub_to_pci_bridge_control_tb;
  import hpbc_pkg::*;
  logic        mclk, nrst, reg_wr, reg_rd, pci_cyc_valid, pci_cyc_io, pci_cyc_hit;
  logic        hub_io_valid, hub_io_local, serr_n, nmi_to_smi, pci_par_err;
  logic        pci_ma_valid, pci_ma_posted, pci_ma_read, hub_ma_valid, cmp_valid;
  logic        prd_valid, prd_target_abort, prd_flush, pci_claim, hub_io_to_pci;
  logic        nmi_req, system_management_interrupt, perr_report;
  logic [1:0]  cmp_status;
  logic [4:0]  pci_ma_dwords;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, reg_rdata;
  logic [31:0] hub_ma_data, cmp_data, prd_data, pci_cyc_addr;
  int          failures = 0;
  int          comparisons = 0;

  hpbc_top dut (.mclk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .pci_ma_valid, .pci_ma_posted, .pci_ma_read, .pci_ma_dwords, .cmp_valid, .cmp_status,
    .cmp_data, .hub_ma_valid, .hub_ma_data, .prd_valid, .prd_data, .prd_target_abort,
    .prd_flush, .pci_cyc_valid, .pci_cyc_io, .pci_cyc_hit, .pci_cyc_addr, .pci_claim,
    .hub_io_valid, .hub_io_local, .hub_io_to_pci, .serr_n, .nmi_to_smi, .nmi_req,
    .system_management_interrupt, .pci_par_err, .perr_report);
  hpbc_partner far (.mclk, .pci_ma_valid, .pci_ma_posted, .pci_ma_read, .pci_ma_dwords,
    .hub_ma_valid, .hub_ma_data);

  always #12.5 mclk = ~mclk;

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task automatic give_verdict();
    $display("comparisons=%0d failures=%0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk({16'h0, reg_rdata}, {16'h0, e});
  endtask
  task automatic beats(input int n, input logic [1:0] st, input logic [31:0] d);
    for (int i = 0; i < n; i++)
    begin
      #1 chk({29'h0, cmp_valid, cmp_status}, {29'h0, 1'b1, st});
      chk(cmp_data, d);
      @(posedge mclk);
    end
    #1 chk({31'h0, cmp_valid}, 32'h0);
  endtask
  task automatic hub(input logic [31:0] d, input logic m);
    far.hub_abort(d);
    #1 chk({29'h0, prd_valid, prd_target_abort, prd_flush}, m ? 32'h3 : 32'h4);
    chk(prd_data, m ? 32'h0 : d);
  endtask
  task automatic cyc(input logic io, input logic [31:0] a, input logic e);
    @(posedge mclk);
    pci_cyc_valid <= 1'b1;
    pci_cyc_io    <= io;
    pci_cyc_addr  <= a;
    pci_cyc_hit   <= 1'b1;
    @(posedge mclk);
    pci_cyc_valid <= 1'b0;
    #1 chk({31'h0, pci_claim}, {31'h0, e});
  endtask
  task automatic pins(input logic s, input logic p, input logic h, input logic [2:0] e);
    @(posedge mclk);
    serr_n       <= ~s;
    pci_par_err  <= p;
    hub_io_valid <= h;
    @(posedge mclk);
    {serr_n, pci_par_err, hub_io_valid} <= 3'b100;
    #1 chk({28'h0, nmi_req, system_management_interrupt, perr_report, hub_io_to_pci},
      {28'h0, e[2] && !nmi_to_smi, e[2] && nmi_to_smi, e[1:0]});
  endtask

  task automatic t_regs();
    rd(ADDR_BCTL, 16'h0000);
    wr(ADDR_BCTL, 16'hffff);
    rd(ADDR_BCTL, 16'h0b3f);
    wr(ADDR_CMD, 16'hffff);
    rd(ADDR_CMD, 16'h0100);
    wr(8'h10, 16'hffff);
    rd(8'h10, 16'h0000);
    wr(ADDR_BCTL, 16'h0000);
    rd(ADDR_BCTL, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_abort(input logic m);
    wr(ADDR_BCTL, {10'h0, m, 5'h02});
    far.pci_abort(1'b0, 1'b1, 5'h10);
    beats(16, m ? CST_TARGET_AB : CST_MASTER_AB, 32'hffff_ffff);
    far.pci_abort(1'b0, 1'b0, 5'h01);
    beats(1, m ? CST_TARGET_AB : CST_MASTER_AB, 32'h0);
    far.pci_abort(1'b1, 1'b0, 5'h01);
    #1 chk({31'h0, cmp_valid}, 32'h0);
    rd(ADDR_STS, m ? 16'h4000 : 16'h0000);
    wr(ADDR_STS, 16'h4000);
    rd(ADDR_STS, 16'h0000);
    hub(32'h5a3c_0f96, m);
    hub(32'ha5c3_f069, m);
    $display("t_abort mode %0d done", m);
  endtask
  task automatic t_decode();
    wr(ADDR_BCTL, 16'h0000);
    cyc(1'b0, 32'h000a_0000, 1'b1);
    cyc(1'b1, 32'h0000_03c0, 1'b0);
    wr(ADDR_BCTL, 16'h0018);
    cyc(1'b0, 32'h000a_0000, 1'b0);
    cyc(1'b0, 32'h000b_ffff, 1'b0);
    cyc(1'b0, 32'h0009_ffff, 1'b1);
    cyc(1'b0, 32'h000c_0000, 1'b1);
    cyc(1'b1, 32'h0000_03b0, 1'b0);
    cyc(1'b1, 32'h0000_03df, 1'b0);
    cyc(1'b1, 32'h0000_03bc, 1'b1);
    $display("t_decode done");
  endtask
  task automatic t_pins();
    wr(ADDR_BCTL, 16'h0006);
    wr(ADDR_CMD, 16'h0000);
    hub_io_local <= 1'b1;
    pins(1'b1, 1'b1, 1'b1, 3'b000);
    @(posedge mclk);
    hub_io_local <= 1'b0;
    pins(1'b0, 1'b0, 1'b1, 3'b001);
    wr(ADDR_CMD, 16'h0100);
    pins(1'b1, 1'b0, 1'b0, 3'b100);
    rd(ADDR_STS, 16'h4000);
    @(posedge mclk);
    nmi_to_smi <= 1'b1;
    wr(ADDR_BCTL, 16'h0003);
    pins(1'b1, 1'b1, 1'b0, 3'b110);
    $display("t_pins done");
  endtask

  initial
  begin
    {mclk, nrst, reg_wr, reg_rd, pci_cyc_valid, pci_cyc_io, pci_cyc_hit} = '0;
    {hub_io_valid, hub_io_local, nmi_to_smi, pci_par_err} = '0;
    {reg_addr, reg_wdata, pci_cyc_addr} = '0;
    serr_n = 1'b1;
    repeat (8) @(posedge mclk);
    nrst <= 1'b1;
    t_regs();
    t_abort(1'b0);
    t_abort(1'b1);
    t_decode();
    t_pins();
    give_verdict();
  end
endmodule
